// >>> dac_pwm_pkg.sv
// constants and types shared by the eight-channel pulse-width D/A block
//
// Overview of operation
// (R1) eight 8-bit read/write duty registers, one per pulse channel
// (R2) high nibble sets basic pulse duty 0/16 to 15/16 in 1/16 steps
// (R3) low nibble sets extra pulse count over sixteen basic pulses
// (R4) ratios 0/256 to 255/256; full scale needs port output by software
// (R5) phase bit per channel: clear gives high time, set inverts
// (R6) pin: direction 0 input, 1 with enable 0 port, 1 with 1 pulse
// (R7) port output drives latch; software preloads full-scale level
// (R8) divider select bits 3..1 with on and prescale bits pick the clock
// (R9) divider select bits 7..4 and 0 reset to zero, ignore writes
// (R10) extra pulse: one resolution active just before basic rising edge
// (R11) zero high nibble: extra pulses still placed at same slot timing
// (R12) extra pulses fill first N slots of fixed order, never slot 0
// (R13) reset leaves block stopped; registers usable once stop is cleared
// (R14) clock off, system clock, or divided by 2..4096 per select field
// (R15) one counter tick is the resolution; period is 256 ticks
// (R16) four-bit pick chooses duty register 0..7; top bit set: no effect
// (R17) shared 8-bit counter: upper nibble slot, lower nibble position
// (R18) new duty values take effect at next conversion period start
`default_nettype none
package dac_pwm_pkg;
   localparam int          CHANNELS     = 8;
   localparam int          ADDR_W       = 8;
   localparam int          DIV_W        = 12;
   // register byte addresses
   localparam logic [7:0]  ADR_SELECT   = 8'h00;
   localparam logic [7:0]  ADR_DUTY     = 8'h04;
   localparam logic [7:0]  ADR_PHASE    = 8'h08;
   localparam logic [7:0]  ADR_PINEN    = 8'h0C;
   localparam logic [7:0]  ADR_DIVSEL   = 8'h10;
   localparam logic [7:0]  ADR_PORTDIR  = 8'h14;
   localparam logic [7:0]  ADR_PORTLAT  = 8'h18;
   localparam logic [7:0]  ADR_STOP     = 8'h1C;
   localparam logic [7:0]  ADR_STATUS   = 8'h20;
   // clock_and_channel_select fields
   localparam int          SEL_ON_BIT   = 7;
   localparam int          SEL_PRE_BIT  = 6;
   localparam logic [7:0]  SEL_FIXED    = 8'h20;
   localparam logic [7:0]  SEL_WMASK    = 8'hCF;
   // counter_clock_divider_select writable field
   localparam logic [7:0]  DIVSEL_WMASK = 8'h0E;
   localparam int          DIVSEL_LSB   = 1;
   // reset values
   localparam logic [7:0]  SEL_RST      = 8'h00;
   localparam logic [7:0]  REG8_RST     = 8'h00;
   localparam logic        STOP_RST     = 1'b1;
   // prescaler masks for divide by 2,4,8,16,256,512,1024,4096
   localparam logic [DIV_W-1:0] DIV_MASK [8] = '{
      12'h001, 12'h003, 12'h007, 12'h00F,
      12'h0FF, 12'h1FF, 12'h3FF, 12'hFFF};

   typedef struct packed {
      logic [7:0] sel;
      logic [7:0] phase;
      logic [7:0] pinen;
      logic [7:0] divsel;
      logic [7:0] portdir;
      logic [7:0] portlat;
      logic       stop;
   } ctl_regs_t;

   typedef struct packed {
      logic [7:0] level;
      logic [7:0] enable;
   } pin_drive_t;
endpackage
`default_nettype wire

// >>> duty_store.sv
// storage for the eight channel duty data words
`default_nettype none
module duty_store
   import dac_pwm_pkg::*;
#(
   parameter int WORDS = 8,
   parameter int WIDTH = 8
)(
   input  wire logic                     core_clk,
   input  wire logic                     sys_rst,
   input  wire logic                     wr_en,
   input  wire logic [2:0]               wr_idx,
   input  wire logic [WIDTH-1:0]         wr_data,
   input  wire logic [2:0]               rd_idx,
   output logic      [WIDTH-1:0]         rd_data,
   output logic      [WORDS*WIDTH-1:0]   all_words
);
   logic [WIDTH-1:0] mem_r [WORDS];
   logic [WIDTH-1:0] rd_r;
   logic [WIDTH-1:0] rd_nxt;

   always_comb
   begin
      rd_nxt = mem_r[rd_idx];
   end

   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
         rd_r <= '0;
      else
         rd_r <= rd_nxt;
   end

   genvar g;
   for (g = 0; g < WORDS; g++)
   begin : g_word
      always_ff @(posedge core_clk or posedge sys_rst)
      begin
         if (sys_rst)
            mem_r[g] <= '0;
         else if (wr_en && wr_idx == 3'(g))
            mem_r[g] <= wr_data; // R1
      end
      assign all_words[g*WIDTH +: WIDTH] = mem_r[g];
   end

   assign rd_data = rd_r;
endmodule // duty_store
`default_nettype wire

// >>> dac_pwm.sv
// eight-channel pulse-width D/A generator with APB registers
//
// Chosen here: the address map and the APB interface to the registers.
`default_nettype none
module dac_pwm
   import dac_pwm_pkg::*;
#(
   parameter int NCH = CHANNELS
)(
   input  wire logic              core_clk,
   input  wire logic              sys_rst,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic [NCH-1:0]    pin_in,
   output logic      [NCH-1:0]    pulse_outputs,
   output logic      [NCH-1:0]    pin_oe
);
   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   ctl_regs_t        regs_r;
   ctl_regs_t        regs_nxt;
   logic [7:0]       cnt_r;
   logic [7:0]       cnt_nxt;
   logic [DIV_W-1:0] div_r;
   logic [DIV_W-1:0] div_nxt;
   logic [31:0]      prdata_r;
   logic [31:0]      prdata_nxt;
   logic [NCH-1:0]   sync1_r;
   logic [NCH-1:0]   sync2_r;
   logic [NCH-1:0]   sync3_r;
   logic [NCH-1:0]   pin_lvl_r;
   logic [NCH-1:0]   pin_lvl_nxt;
   logic [7:0]       shadow_r [NCH];
   logic [7:0]       shadow_nxt [NCH];
   logic [NCH-1:0]   wave_r;
   logic [NCH-1:0]   wave_nxt;
   pin_drive_t       drive;
   logic             setup;
   logic             access;
   logic             wr_acc;
   logic             mapped;
   logic             tick;
   logic             period_end;
   logic             duty_wr;
   logic [2:0]       pick_idx;
   logic             pick_ok;
   logic [7:0]       duty_rd;
   logic [NCH*8-1:0] duty_all;
   logic [3:0]       slot;
   logic [3:0]       pos;
   logic [3:0]       slot_rev;
   logic [2:0]       div_code;

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   assign setup  = psel && !penable;
   assign access = psel && penable;
   assign wr_acc = access && pwrite;

   always_comb
   begin
      case (paddr)
         ADR_SELECT,
         ADR_DUTY,
         ADR_PHASE,
         ADR_PINEN,
         ADR_DIVSEL,
         ADR_PORTDIR,
         ADR_PORTLAT,
         ADR_STOP,
         ADR_STATUS: mapped = 1'b1;
         default:    mapped = 1'b0;
      endcase
   end

   // zero wait states: duty read is fetched during the setup cycle
   assign pready  = access;
   assign pslverr = access && !mapped;
   assign prdata  = prdata_r;

   // a pick with the top bit set reaches no duty word
   assign pick_ok  = !regs_r.sel[3]; // R16
   assign pick_idx = regs_r.sel[2:0]; // R16
   assign duty_wr  = wr_acc && paddr == ADR_DUTY && pick_ok
                     && !regs_r.stop; // R13

   // ------------------------------------------------------------
   // duty data storage
   // ------------------------------------------------------------
   duty_store #(
      .WORDS (NCH),
      .WIDTH (8)
   ) u_store (
      .core_clk  (core_clk),
      .sys_rst   (sys_rst),
      .wr_en     (duty_wr),
      .wr_idx    (pick_idx),
      .wr_data   (pwdata[7:0]),
      .rd_idx    (pick_idx),
      .rd_data   (duty_rd),
      .all_words (duty_all)
   );

   // ------------------------------------------------------------
   // control registers
   // ------------------------------------------------------------
   always_comb
   begin
      regs_nxt = regs_r;
      if (wr_acc && paddr == ADR_STOP)
         regs_nxt.stop = pwdata[0];
      // while stopped only the stop control accepts writes
      if (wr_acc && !regs_r.stop) // R13
      begin
         case (paddr)
            ADR_SELECT:
               regs_nxt.sel = (pwdata[7:0] & SEL_WMASK) | SEL_FIXED;
            ADR_PHASE:
               regs_nxt.phase = pwdata[7:0]; // R5
            ADR_PINEN:
               regs_nxt.pinen = pwdata[7:0]; // R6
            ADR_DIVSEL:
               regs_nxt.divsel = pwdata[7:0] & DIVSEL_WMASK; // R9
            ADR_PORTDIR:
               regs_nxt.portdir = pwdata[7:0]; // R6
            ADR_PORTLAT:
               regs_nxt.portlat = pwdata[7:0]; // R7
            default:
               regs_nxt.stop = regs_nxt.stop;
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         regs_r.sel     <= SEL_RST | SEL_FIXED;
         regs_r.phase   <= REG8_RST;
         regs_r.pinen   <= REG8_RST;
         regs_r.divsel  <= REG8_RST; // R9
         regs_r.portdir <= REG8_RST;
         regs_r.portlat <= REG8_RST;
         regs_r.stop    <= STOP_RST; // R13
      end
      else
         regs_r <= regs_nxt;
   end

   // ------------------------------------------------------------
   // read data
   // ------------------------------------------------------------
   always_comb
   begin
      prdata_nxt = prdata_r;
      if (setup)
      begin
         prdata_nxt = '0;
         if (paddr == ADR_STOP)
            prdata_nxt = {31'h0, regs_r.stop};
         else if (!regs_r.stop) // R13
         begin
            case (paddr)
               ADR_SELECT:  prdata_nxt = {24'h0, regs_r.sel};
               ADR_DUTY:
                  prdata_nxt = pick_ok ? {24'h0, duty_rd} : '0; // R1
               ADR_PHASE:   prdata_nxt = {24'h0, regs_r.phase};
               ADR_PINEN:   prdata_nxt = {24'h0, regs_r.pinen};
               ADR_DIVSEL:  prdata_nxt = {24'h0, regs_r.divsel};
               ADR_PORTDIR: prdata_nxt = {24'h0, regs_r.portdir};
               ADR_PORTLAT: prdata_nxt = {24'h0, regs_r.portlat};
               ADR_STATUS:
                  prdata_nxt = {16'h0, pin_lvl_r, cnt_r};
               default:     prdata_nxt = '0;
            endcase
         end
      end
   end

   // read data must be stable in the access cycle, so the
   // register is loaded from the setup cycle decode
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
         prdata_r <= '0;
      else if (setup)
         prdata_r <= prdata_nxt;
   end

   // limitation: status shows the counter as it stood at setup,
   // one cycle older than the access cycle

   // ------------------------------------------------------------
   // pin level sampling
   // ------------------------------------------------------------
   // a level change counts once the last two stages agree
   always_comb
   begin
      pin_lvl_nxt = pin_lvl_r;
      for (int i = 0; i < NCH; i++)
         if (sync2_r[i] == sync3_r[i])
            pin_lvl_nxt[i] = sync3_r[i];
   end

   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         sync1_r   <= '0;
         sync2_r   <= '0;
         sync3_r   <= '0;
         pin_lvl_r <= '0;
      end
      else
      begin
         sync1_r   <= pin_in;
         sync2_r   <= sync1_r;
         sync3_r   <= sync2_r;
         pin_lvl_r <= pin_lvl_nxt;
      end
   end

   // ------------------------------------------------------------
   // prescaler and conversion counter
   // ------------------------------------------------------------
   assign div_code = regs_r.divsel[DIVSEL_LSB +: 3]; // R8

   always_comb
   begin
      tick = 1'b0;
      if (!regs_r.stop && regs_r.sel[SEL_ON_BIT]) // R14
      begin
         if (!regs_r.sel[SEL_PRE_BIT])
            tick = 1'b1; // R14
         else
            tick = &(div_r | ~DIV_MASK[div_code]); // R14
      end
   end

   // one tick is one resolution; 256 ticks make a period
   assign period_end = tick && cnt_r == 8'hFF; // R15
   assign slot = cnt_r[7:4]; // R17
   assign pos  = cnt_r[3:0]; // R17
   assign slot_rev = {slot[0], slot[1], slot[2], slot[3]};

   always_comb
   begin
      div_nxt = div_r + DIV_W'(1);
      cnt_nxt = cnt_r;
      if (regs_r.stop || !regs_r.sel[SEL_ON_BIT])
         div_nxt = '0;
      if (regs_r.stop)
         cnt_nxt = '0; // R13
      else if (tick)
         cnt_nxt = cnt_r + 8'h01; // R17
   end

   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         div_r <= '0;
         cnt_r <= '0;
      end
      else
      begin
         div_r <= div_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // ------------------------------------------------------------
   // waveform per channel
   // ------------------------------------------------------------
   // the shadow copy keeps a period whole when software writes
   genvar c;
   for (c = 0; c < NCH; c++)
   begin : g_ch
      logic [3:0] hi;
      logic [3:0] lo;
      logic       basic;
      logic       extra;
      logic       act;
      logic [4:0] rise_sum;
      logic [4:0] rank_sum;

      assign hi = shadow_r[c][7:4]; // R2
      assign lo = shadow_r[c][3:0]; // R3

      // basic pulse rises at position 16-hi and holds to slot end
      assign rise_sum = {1'b0, pos} + {1'b0, hi};
      assign basic    = rise_sum[4]; // R2

      // reversed slot bits give the fill order; slot 0 ranks last
      assign rank_sum = {1'b0, slot_rev} + {1'b0, lo};
      assign extra    = rank_sum[4] && slot != 4'h0 // R12
                        && pos == 4'hF - hi; // R10 R11

      // at most 255 of 256 ticks can be active
      assign act = basic || extra; // R4

      always_comb
      begin
         shadow_nxt[c] = shadow_r[c];
         if (regs_r.stop || period_end)
            shadow_nxt[c] = duty_all[c*8 +: 8]; // R18
         wave_nxt[c] = act ^ regs_r.phase[c]; // R5
      end

      always_ff @(posedge core_clk or posedge sys_rst)
      begin
         if (sys_rst)
         begin
            shadow_r[c] <= '0;
            wave_r[c]   <= 1'b0;
         end
         else
         begin
            shadow_r[c] <= shadow_nxt[c];
            wave_r[c]   <= wave_nxt[c];
         end
      end
   end

   // ------------------------------------------------------------
   // pin function
   // ------------------------------------------------------------
   always_comb
   begin
      drive.enable = regs_r.portdir; // R6
      drive.level  = regs_r.portlat; // R7
      for (int i = 0; i < NCH; i++)
         if (regs_r.portdir[i] && regs_r.pinen[i])
            drive.level[i] = wave_r[i]; // R6
   end

   assign pulse_outputs = drive.level;
   assign pin_oe        = drive.enable;

endmodule // dac_pwm
`default_nettype wire

// >>> dac_pwm_monitor.sv
// port checker for the pulse-width D/A block
`default_nettype none
module dac_pwm_monitor
   import dac_pwm_pkg::*;
#(
   parameter int NCH = CHANNELS
)(
   input wire logic              core_clk,
   input wire logic              sys_rst,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic [NCH-1:0]    pin_in,
   input wire logic [NCH-1:0]    pulse_outputs,
   input wire logic [NCH-1:0]    pin_oe
);
   // ------
   // bus and pin relations
   // ------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);
   logic acc;
   assign acc = psel & penable;
   a_ready_zero_wait: assert property (
      acc |-> pready) else $error("no pready in access");
   a_ready_one_cycle: assert property (
      pready |=> !pready && !pslverr) else $error("pready held");
   a_err_in_access: assert property (
      pslverr |-> acc && prdata == 32'h0) else $error("bad pslverr");
   a_mapped_no_err: assert property (
      acc && paddr <= ADR_STATUS && paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("pslverr on mapped address");
   a_oe_on_write: assert property (
      $changed(pin_oe) |-> $past(acc && pwrite && paddr == ADR_PORTDIR))
      else $error("pin enable moved without write");
   a_high_bits_zero: assert property (
      pready && !pwrite && paddr != ADR_STATUS |-> prdata[31:8] == 24'h0)
      else $error("upper read bits set");
   a_divsel_reserved: assert property (
      pready && !pwrite && paddr == ADR_DIVSEL |->
      prdata[7:4] == 4'h0 && !prdata[0]) else $error("reserved bit set");
   a_reset_quiet: assert property (
      $fell(sys_rst) |-> pin_oe == '0 && pulse_outputs == '0)
      else $error("pins active after reset");
   c_duty_write: cover property (acc && pwrite && paddr == ADR_DUTY);
   c_bus_error: cover property (pslverr);
   c_pin_drive: cover property ($rose(pin_oe[0]));
endmodule // dac_pwm_monitor
bind dac_pwm dac_pwm_monitor #(.NCH(NCH)) u_monitor (
   .core_clk(core_clk),
   .sys_rst(sys_rst),
   .psel(psel),
   .penable(penable),
   .pwrite(pwrite),
   .paddr(paddr),
   .pwdata(pwdata),
   .prdata(prdata),
   .pready(pready),
   .pslverr(pslverr),
   .pin_in(pin_in),
   .pulse_outputs(pulse_outputs),
   .pin_oe(pin_oe)
);
`default_nettype wire

// >>> lp_filter_model.sv
// low-pass filter on the pulse pins, modelled as a 256-tick integrator
`default_nettype none
module lp_filter_model (
   input  wire logic       core_clk,
   input  wire logic [7:0] level,
   input  wire logic [7:0] oe,
   input  wire logic       start,
   output logic      [7:0] pin_in,
   output logic            busy,
   output logic      [8:0] sums [8]
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] alt = 8'h55;
   int         left = 0;
   // an undriven pin has no pull, so it wanders every cycle
   assign pin_in = (oe & level) | (~oe & alt);
   assign busy = (left != 0) || (start === 1'h1);
   always @(posedge core_clk)
   begin
      alt <= ~alt;
      if (start === 1'h1)
      begin
         left <= 256;
         sums <= '{default: 9'h0};
      end
      else if (left > 0)
      begin
         left <= left - 1;
         for (int i = 0; i < 8; i++)
            sums[i] <= sums[i] + 9'(level[i]);
      end
   end
endmodule // lp_filter_model
`default_nettype wire

// >>> eight_channel_dac_pwm_tb_top.sv
// self-checking bench for the pulse-width D/A block
`default_nettype none
module eight_channel_dac_pwm_tb_top
   import dac_pwm_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic        core_clk, sys_rst, psel, penable, pwrite;
   logic [7:0]  paddr, pin_in, pulse_outputs, pin_oe, ph, c0;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, start, busy, er;
   logic [8:0]  sums [8];
   logic [7:0]  dv [8];
   int          fails = 0;
   int          checked = 0;
   int          cycles = 0;
   int          seed = 32'hF7ED;
   int          divs [10] = '{1, 1, 2, 4, 8, 16, 256, 512, 1024, 4096};
   logic [7:0]  corner [8] = '{8'h00, 8'hFF, 8'h01, 8'h10,
                               8'h0F, 8'hF0, 8'h80, 8'h7F};
   dac_pwm #(.NCH(8)) dut (.core_clk(core_clk), .sys_rst(sys_rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pin_in(pin_in),
      .pulse_outputs(pulse_outputs), .pin_oe(pin_oe));
   lp_filter_model u_filter (.core_clk(core_clk), .level(pulse_outputs),
      .oe(pin_oe), .start(start), .pin_in(pin_in), .busy(busy),
      .sums(sums));
   initial
   begin
      core_clk = 1'h0;
      forever #5 core_clk = ~core_clk;
   end
   // ------
   // checking and bus tasks
   // ------
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         fails++;
         give_verdict();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // waits for pready as long as it takes; only the bench timeout
   // ends a hang
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] wd);
      @(posedge core_clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'h1;
      do
         @(posedge core_clk);
      while (pready !== 1'h1);
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'h0, a, 32'h0);
      chk(rd, e);
   endtask
   function automatic logic [8:0] want(input logic [7:0] v, input logic p);
      return p ? 9'h100 - {1'h0, v} : {1'h0, v};
   endfunction
   // ------
   // main sequence
   // ------
   initial
   begin
      {sys_rst, psel, penable, pwrite, start} = 5'h10;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (3) @(posedge core_clk);
      sys_rst <= 1'h0;
      rdchk(ADR_STOP, 32'h1);
      apb(1'h1, ADR_PHASE, 32'hFF);
      rdchk(ADR_PHASE, 32'h0);
      apb(1'h1, ADR_STOP, 32'h0);
      rdchk(ADR_SELECT, 32'h20);
      rdchk(ADR_PINEN, 32'h0);
      apb(1'h1, ADR_DIVSEL, 32'hFF);
      rdchk(ADR_DIVSEL, 32'h0E);
      apb(1'h1, 8'h24, 32'h0);
      chk(32'(er), 32'h1);
      apb(1'h1, ADR_SELECT, 32'h08);
      apb(1'h1, ADR_DUTY, 32'h55);
      rdchk(ADR_DUTY, 32'h0);
      apb(1'h1, ADR_SELECT, 32'h00);
      rdchk(ADR_DUTY, 32'h0);
      $display("test registers done");
      apb(1'h1, ADR_PORTDIR, 32'hFF);
      apb(1'h1, ADR_PINEN, 32'hFF);
      for (int r = 0; r < 3; r++)
      begin
         for (int c = 0; c < 8; c++)
         begin
            dv[c] = (r == 0) ? corner[c] : 8'($random(seed));
            apb(1'h1, ADR_SELECT, 32'h80 | c);
            apb(1'h1, ADR_DUTY, {24'h0, dv[c]});
            rdchk(ADR_DUTY, {24'h0, dv[c]});
         end
         ph = (r == 0) ? 8'h00 : (r == 1) ? 8'hFF : 8'($random(seed));
         apb(1'h1, ADR_PHASE, {24'h0, ph});
         // two periods so the new duty is surely in force
         repeat (520) @(posedge core_clk);
         start <= 1'h1;
         @(posedge core_clk);
         start <= 1'h0;
         while (busy === 1'h1)
            @(posedge core_clk);
         for (int c = 0; c < 8; c++)
            chk(32'(sums[c]), 32'(want(dv[c], ph[c])));
         $display("test pulse round %0d done", r);
      end
      apb(1'h1, ADR_PINEN, 32'h0);
      apb(1'h1, ADR_PORTLAT, 32'hA5);
      repeat (2) @(posedge core_clk);
      chk(32'(pulse_outputs), 32'hA5);
      apb(1'h1, ADR_PORTDIR, 32'h3C);
      repeat (4) @(posedge core_clk);
      chk(32'(pin_oe), 32'h3C);
      apb(1'h0, ADR_STATUS, 32'h0);
      chk(32'(rd[15:8] & 8'h3C), 32'h24);
      $display("test port mode done");
      for (int k = 0; k < 10; k++)
      begin
         if (k > 1)
            apb(1'h1, ADR_DIVSEL, 32'((k - 2) << 1));
         apb(1'h1, ADR_SELECT, k == 0 ? 32'h0 : k == 1 ? 32'h80 : 32'hC0);
         apb(1'h0, ADR_STATUS, 32'h0);
         c0 = rd[7:0];
         repeat (4 * divs[k] - 3) @(posedge core_clk);
         apb(1'h0, ADR_STATUS, 32'h0);
         chk(32'(8'(rd[7:0] - c0)), k == 0 ? 32'h0 : 32'h4);
      end
      $display("test clock select done");
      give_verdict();
   end
endmodule // eight_channel_dac_pwm_tb_top
`default_nettype wire
